// >>> verilog/bsc_cfg.svh
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// Widths
`define BSC_PC_W 13
`define BSC_OFS_W 12
`define BSC_PTR_W 16
`define BSC_CNT_W 2

// Status flag bit positions
`define BSC_FLG_C 0
`define BSC_FLG_Z 1
`define BSC_FLG_N 2
`define BSC_FLG_V 3
`define BSC_FLG_S 4
`define BSC_FLG_H 5
`define BSC_FLG_T 6
`define BSC_FLG_I 7

// Cycle counts
`define BSC_CYC_JUMP 2'h2
`define BSC_CYC_CALL 2'h3
`define BSC_CYC_ONE 2'h1
`define BSC_CYC_TAKEN 2'h2
`define BSC_CYC_SKIP1 2'h2
`define BSC_CYC_SKIP2 2'h3

// Program counter advances
`define BSC_PC_STEP 13'h0001
`define BSC_SKIP_ONE 13'h0002
`define BSC_SKIP_TWO 13'h0003

// Reset values
`define BSC_RST_PC 13'h0000
`define BSC_RST_FLAGS 8'h00

`endif

// >>> verilog/bsc_pkg.sv
package bsc_pkg;
  typedef enum logic [4:0] {
    op_relative_jump,
    op_pointer_jump,
    op_pointer_call,
    op_compare_skip_equal,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear,
    op_branch_equal,
    op_branch_unequal,
    op_branch_carry_one,
    op_branch_carry_zero,
    op_branch_same_higher,
    op_branch_lower,
    op_branch_negative,
    op_branch_positive,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_halfcarry_one,
    op_branch_halfcarry_zero,
    op_branch_transfer_one,
    op_branch_transfer_zero,
    op_branch_overflow_one
  } bsc_op_t;
endpackage

// >>> verilog/bsc_cond_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bsc_cond_if;
  import bsc_pkg::*;
  bsc_op_t op;
  logic [7:0] flags;
  logic [2:0] bit_sel;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [7:0] io_val;
  logic is_branch;
  logic is_skip;
  logic cond;
  modport eval (
    input op, flags, bit_sel, rd_val, rr_val, io_val,
    output is_branch, is_skip, cond
  );
  modport user (
    output op, flags, bit_sel, rd_val, rr_val, io_val,
    input is_branch, is_skip, cond
  );
endinterface
`default_nettype wire

// >>> verilog/bsc_cond_eval.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_cond_eval (
  bsc_cond_if.eval c
);
  import bsc_pkg::*;
  logic [2:0] sel;
  logic want;
  logic branch;
  wire sign_test = c.flags[`BSC_FLG_N] ^ c.flags[`BSC_FLG_V];
  wire sel_flag = c.flags[sel];
  wire reg_bit = c.rd_val[c.bit_sel];
  wire io_bit = c.io_val[c.bit_sel];

  always_comb begin
    sel = c.bit_sel;
    want = 1'b1;
    branch = 1'b1;
    unique case (c.op)
      op_branch_flag_set: want = 1'b1;
      op_branch_flag_clear: want = 1'b0;
      op_branch_equal: sel = 3'(`BSC_FLG_Z);
      op_branch_unequal: begin
        sel = 3'(`BSC_FLG_Z);
        want = 1'b0;
      end
      op_branch_carry_one, op_branch_lower: sel = 3'(`BSC_FLG_C);
      op_branch_carry_zero, op_branch_same_higher: begin
        sel = 3'(`BSC_FLG_C);
        want = 1'b0;
      end
      op_branch_negative: sel = 3'(`BSC_FLG_N);
      op_branch_positive: begin
        sel = 3'(`BSC_FLG_N);
        want = 1'b0;
      end
      op_branch_signed_ge: want = 1'b0;
      op_branch_signed_lt: want = 1'b1;
      op_branch_halfcarry_one: sel = 3'(`BSC_FLG_H);
      op_branch_halfcarry_zero: begin
        sel = 3'(`BSC_FLG_H);
        want = 1'b0;
      end
      op_branch_transfer_one: sel = 3'(`BSC_FLG_T);
      op_branch_transfer_zero: begin
        sel = 3'(`BSC_FLG_T);
        want = 1'b0;
      end
      op_branch_overflow_one: sel = 3'(`BSC_FLG_V);
      default: branch = 1'b0;
    endcase
  end

  wire signed_op = (c.op == op_branch_signed_ge) ||
                   (c.op == op_branch_signed_lt);
  wire br_cond = ((signed_op ? sign_test : sel_flag) == want);

  assign c.is_skip = (c.op == op_compare_skip_equal) ||
                     (c.op == op_skip_reg_bit_clear) ||
                     (c.op == op_skip_reg_bit_set) ||
                     (c.op == op_skip_io_bit_clear) ||
                     (c.op == op_skip_io_bit_set);
  assign c.is_branch = branch;
  assign c.cond =
    branch ? br_cond :
    (c.op == op_compare_skip_equal) ? (c.rd_val == c.rr_val) :
    (c.op == op_skip_reg_bit_clear) ? !reg_bit :
    (c.op == op_skip_reg_bit_set) ? reg_bit :
    (c.op == op_skip_io_bit_clear) ? !io_bit :
    (c.op == op_skip_io_bit_set) ? io_bit : 1'b0;
endmodule
`default_nettype wire

// >>> verilog/bsc_branch_skip_control.sv
// Contract
// - Relative jump loads PC plus offset plus one, two cycles, flags kept.
// - Pointer jump loads PC from Z pointer, two cycles, flags kept.
// - Pointer call saves return address, jumps to Z, three cycles.
// - Compare-skip-equal skips next instruction when both registers match.
// - Compare-immediate subtracts constant, updates Z N V C H, one cycle.
// - Register bit skips test selected bit clear or set.
// - I/O bit skips test selected I/O bit clear or set, flags kept.
// - Generic flag branches test selected status bit set or clear.
// - Equal branch on Z one, unequal branch on Z zero.
// - Carry-one and lower on C one; carry-zero and same-higher on zero.
// - Negative branch on N one, positive branch on N zero.
// - Signed greater-or-equal branch taken when N xor V is zero.
// - Half-carry branches on H one or H zero.
// - Transfer branches on T one or T zero.
// - Overflow branch taken only when V is one.
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_branch_skip_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire bsc_pkg::bsc_op_t issue_op,
  input wire logic [`BSC_PC_W-1:0] pc,
  input wire logic [`BSC_OFS_W-1:0] offset,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm_val,
  input wire logic [7:0] io_val,
  input wire logic [`BSC_PTR_W-1:0] z_ptr,
  input wire logic next_two_word,
  input wire logic [7:0] flags_in,
  output logic pc_load,
  output logic [`BSC_PC_W-1:0] pc_target,
  output logic push_ret,
  output logic [`BSC_PC_W-1:0] ret_addr,
  output logic flags_we,
  output logic [7:0] flags_out,
  output logic busy
);
  import bsc_pkg::*;

  bsc_cond_if cif ();
  bsc_cond_eval u_eval (
    .c(cif)
  );

  logic [`BSC_CNT_W-1:0] busy_cnt_r;
  logic pc_load_r;
  logic [`BSC_PC_W-1:0] pc_target_r;
  logic push_r;
  logic [`BSC_PC_W-1:0] ret_addr_r;
  logic flags_we_r;
  logic [7:0] flags_r;

  assign cif.op = issue_op;
  assign cif.flags = flags_in;
  assign cif.bit_sel = bit_sel;
  assign cif.rd_val = rd_val;
  assign cif.rr_val = rr_val;
  assign cif.io_val = io_val;

  // Next instruction is held off while a multi-cycle one drains
  wire idle = (busy_cnt_r == '0);
  assign issue_ready = ce && idle;
  wire fire = issue_valid && issue_ready;

  wire [`BSC_PC_W-1:0] ofs_ext =
    {{(`BSC_PC_W-`BSC_OFS_W){offset[`BSC_OFS_W-1]}}, offset};
  wire [`BSC_PC_W-1:0] rel_target = pc + ofs_ext + `BSC_PC_STEP;
  wire [`BSC_PC_W-1:0] skip_target =
    pc + (next_two_word ? `BSC_SKIP_TWO : `BSC_SKIP_ONE);
  wire [`BSC_PC_W-1:0] z_target = z_ptr[`BSC_PC_W-1:0];
  wire [`BSC_PC_W-1:0] call_ret = pc + `BSC_PC_STEP;

  wire is_rel_jump = (issue_op == op_relative_jump);
  wire is_ptr_jump = (issue_op == op_pointer_jump);
  wire is_call = (issue_op == op_pointer_call);
  wire is_cmp_imm = (issue_op == op_compare_immediate);
  wire br_taken = cif.is_branch && cif.cond;
  wire skip_taken = cif.is_skip && cif.cond;

  wire take = is_rel_jump || is_ptr_jump || is_call || br_taken ||
              skip_taken;
  wire [`BSC_PC_W-1:0] target =
    (is_ptr_jump || is_call) ? z_target :
    skip_taken ? skip_target :
    rel_target;

  // Skip length depends on the width of the instruction being passed over
  wire [`BSC_CNT_W-1:0] skip_cyc =
    next_two_word ? `BSC_CYC_SKIP2 : `BSC_CYC_SKIP1;
  wire [`BSC_CNT_W-1:0] cycles =
    is_call ? `BSC_CYC_CALL :
    (is_rel_jump || is_ptr_jump) ? `BSC_CYC_JUMP :
    skip_taken ? skip_cyc :
    br_taken ? `BSC_CYC_TAKEN :
    `BSC_CYC_ONE;

  // Compare with immediate: difference is discarded, only flags survive
  wire [7:0] diff = rd_val - imm_val;
  wire cmp_h = (~rd_val[3] & imm_val[3]) | (imm_val[3] & diff[3]) |
               (diff[3] & ~rd_val[3]);
  wire cmp_c = (~rd_val[7] & imm_val[7]) | (imm_val[7] & diff[7]) |
               (diff[7] & ~rd_val[7]);
  wire cmp_v = (rd_val[7] & ~imm_val[7] & ~diff[7]) |
               (~rd_val[7] & imm_val[7] & diff[7]);
  logic [7:0] cmp_flags;
  always_comb begin
    cmp_flags = flags_in;
    cmp_flags[`BSC_FLG_Z] = (diff == 8'h00);
    cmp_flags[`BSC_FLG_N] = diff[7];
    cmp_flags[`BSC_FLG_V] = cmp_v;
    cmp_flags[`BSC_FLG_C] = cmp_c;
    cmp_flags[`BSC_FLG_H] = cmp_h;
  end

  wire [`BSC_CNT_W-1:0] cnt_nxt =
    fire ? cycles - `BSC_CYC_ONE :
    idle ? busy_cnt_r : busy_cnt_r - `BSC_CYC_ONE;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_cnt_r <= '0;
      pc_load_r <= 1'b0;
      pc_target_r <= `BSC_RST_PC;
      push_r <= 1'b0;
      ret_addr_r <= `BSC_RST_PC;
      flags_we_r <= 1'b0;
      flags_r <= `BSC_RST_FLAGS;
    end else if (ce) begin
      busy_cnt_r <= cnt_nxt;
      pc_load_r <= fire && take;
      push_r <= fire && is_call;
      // Only compare-immediate touches flags; all flow ops leave them
      flags_we_r <= fire && is_cmp_imm;
      if (fire) begin
        pc_target_r <= target;
        ret_addr_r <= call_ret;
        flags_r <= cmp_flags;
      end
    end
  end

  assign pc_load = pc_load_r;
  assign pc_target = pc_target_r;
  assign push_ret = push_r;
  assign ret_addr = ret_addr_r;
  assign flags_we = flags_we_r;
  assign flags_out = flags_r;
  assign busy = !idle;

  // Checks are abandoned while the clock enable freezes the block
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_fire_op(bsc_op_t o);
    fire && (issue_op == o);
  endsequence

  // Occupancy tails from the result pulse on: one or two busy cycles, the pulse cycle included
  sequence s_drain2;
    busy ##1 !busy;
  endsequence

  sequence s_drain3;
    busy ##1 busy ##1 !busy;
  endsequence

  property p_rel_jump;
    s_fire_op(op_relative_jump) |=>
      (pc_load && !flags_we &&
       pc_target == $past(pc) + $past(ofs_ext) + `BSC_PC_STEP) ##0 s_drain2;
  endproperty
  a_rel_jump: assert property (p_rel_jump)
    else $error("relative jump wrong");

  property p_ptr_jump;
    s_fire_op(op_pointer_jump) |=>
      (pc_load && !flags_we &&
       pc_target == $past(z_ptr[`BSC_PC_W-1:0])) ##0 s_drain2;
  endproperty
  a_ptr_jump: assert property (p_ptr_jump)
    else $error("pointer jump wrong");

  property p_call;
    s_fire_op(op_pointer_call) |=>
      (push_ret && pc_load && !flags_we &&
       ret_addr == $past(pc) + `BSC_PC_STEP &&
       pc_target == $past(z_ptr[`BSC_PC_W-1:0])) ##0 s_drain3;
  endproperty
  a_call: assert property (p_call)
    else $error("pointer call wrong");

  property p_cmp_skip;
    s_fire_op(op_compare_skip_equal) ##0 (rd_val == rr_val && next_two_word)
      |=> (pc_load && pc_target == $past(pc) + `BSC_SKIP_TWO) ##0 s_drain3;
  endproperty
  a_cmp_skip: assert property (p_cmp_skip)
    else $error("compare skip wrong");

  property p_cmp_imm;
    s_fire_op(op_compare_immediate) |=> flags_we && !pc_load && !busy &&
      flags_out[`BSC_FLG_Z] == ($past(rd_val) == $past(imm_val)) &&
      flags_out[`BSC_FLG_C] == ($past(rd_val) < $past(imm_val));
  endproperty
  a_cmp_imm: assert property (p_cmp_imm)
    else $error("compare immediate wrong");

  property p_skipreg;
    s_fire_op(op_skip_reg_bit_set) ##0 !next_two_word |=>
      (pc_load == $past(rd_val[bit_sel]) && busy == pc_load) ##1 !busy;
  endproperty
  a_skipreg: assert property (p_skipreg)
    else $error("reg skip wrong");

  property p_skipio;
    s_fire_op(op_skip_io_bit_clear) |=> pc_load == !$past(io_val[bit_sel])
      && !flags_we;
  endproperty
  a_skipio: assert property (p_skipio)
    else $error("io skip wrong");

  property p_brflag;
    s_fire_op(op_branch_flag_clear) |=> pc_load == !$past(flags_in[bit_sel]);
  endproperty
  a_brflag: assert property (p_brflag)
    else $error("flag branch wrong");

  property p_unequal;
    s_fire_op(op_branch_unequal) ##0 flags_in[`BSC_FLG_Z] |=>
      !pc_load && !busy;
  endproperty
  a_unequal: assert property (p_unequal)
    else $error("unequal branch wrong");

  property p_signed;
    s_fire_op(op_branch_signed_ge) |=>
      pc_load == !($past(flags_in[`BSC_FLG_N]) ^ $past(flags_in[`BSC_FLG_V]));
  endproperty
  a_signed: assert property (p_signed)
    else $error("signed branch wrong");

  property p_signed_lt;
    s_fire_op(op_branch_signed_lt) |=>
      pc_load == ($past(flags_in[`BSC_FLG_N]) ^ $past(flags_in[`BSC_FLG_V]));
  endproperty
  a_signed_lt: assert property (p_signed_lt)
    else $error("signed less branch wrong");

  property p_lower;
    s_fire_op(op_branch_lower) ##0 flags_in[`BSC_FLG_C] |=>
      pc_load ##0 s_drain2;
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower branch wrong");

  property p_ovf;
    s_fire_op(op_branch_overflow_one) |=>
      pc_load == $past(flags_in[`BSC_FLG_V]);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow branch wrong");
endmodule
`default_nettype wire

// >>> verif/bsc_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module bsc_fetch_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pc_load,
  input wire logic [12:0] pc_target,
  input wire logic push_ret,
  input wire logic [12:0] ret_addr,
  output logic [12:0] fetch_pc,
  output logic [12:0] stack_top
);
  // Without a load the fetch side walks forward one word each cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_pc <= 13'h0000;
      stack_top <= 13'h0000;
    end else begin
      fetch_pc <= pc_load ? pc_target : fetch_pc + 13'h0001;
      if (push_ret) stack_top <= ret_addr;
    end
  end
endmodule
`default_nettype wire

// >>> verif/branch_skip_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module branch_skip_control_tb_top;
  import bsc_pkg::*;
  logic clk, rst, ce, issue_valid, next_two_word, issue_ready;
  logic pc_load, push_ret, flags_we, busy;
  bsc_op_t issue_op;
  logic [12:0] pc, pc_target, ret_addr, fetch_pc, stack_top;
  logic [11:0] offset;
  logic [2:0] bit_sel;
  logic [7:0] rd_val, rr_val, imm_val, io_val, flags_in, flags_out;
  logic [15:0] z_ptr;
  int fails, checks_done;
  bsc_op_t bop [17] = '{op_branch_equal, op_branch_unequal,
    op_branch_carry_one, op_branch_lower, op_branch_carry_zero,
    op_branch_same_higher, op_branch_negative, op_branch_positive,
    op_branch_signed_ge, op_branch_signed_lt, op_branch_halfcarry_one,
    op_branch_halfcarry_zero, op_branch_transfer_one,
    op_branch_transfer_zero, op_branch_overflow_one, op_branch_flag_set,
    op_branch_flag_clear};
  // Flags making each branch true, then false
  logic [7:0] bft [17] = '{8'h02, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
    8'h04, 8'h00, 8'h0c, 8'h08, 8'h20, 8'h00, 8'h40, 8'h00, 8'h08,
    8'h80, 8'h00};
  logic [7:0] bff [17] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h04, 8'h04, 8'h0c, 8'h00, 8'h20, 8'h00, 8'h40, 8'h00,
    8'h00, 8'h80};

  bsc_branch_skip_control dut_u (.clk(clk), .rst(rst), .ce(ce),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_op(issue_op), .pc(pc), .offset(offset), .bit_sel(bit_sel),
    .rd_val(rd_val), .rr_val(rr_val), .imm_val(imm_val), .io_val(io_val),
    .z_ptr(z_ptr), .next_two_word(next_two_word), .flags_in(flags_in),
    .pc_load(pc_load), .pc_target(pc_target), .push_ret(push_ret),
    .ret_addr(ret_addr), .flags_we(flags_we), .flags_out(flags_out),
    .busy(busy));
  bsc_fetch_model fetch_u (.clk(clk), .rst(rst), .pc_load(pc_load),
    .pc_target(pc_target), .push_ret(push_ret), .ret_addr(ret_addr),
    .fetch_pc(fetch_pc), .stack_top(stack_top));

  task automatic test_done;
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic setv(logic [7:0] r, logic [7:0] q, logic [7:0] io,
                      logic [2:0] b, logic tw);
    @(posedge clk);
    rd_val <= r;
    rr_val <= q;
    io_val <= io;
    bit_sel <= b;
    next_two_word <= tw;
  endtask

  // Issues one instruction and judges load, target and occupancy
  task automatic run(bsc_op_t op, logic [12:0] p, logic [11:0] k,
                     logic [7:0] fl, logic ld, logic [12:0] tgt,
                     logic we, int cyc);
    int n;
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_op <= op;
    pc <= p;
    offset <= k;
    flags_in <= fl;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    chk("pc_load", ld, pc_load);
    if (ld) chk("pc_target", tgt, pc_target);
    chk("flags_we", we, flags_we);
    chk("push_ret", op == op_pointer_call, push_ret);
    n = 1;
    while (busy === 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("cycles", 16'(cyc), 16'(n));
    if (ld) chk("fetch_pc", tgt + 13'(cyc - 2), fetch_pc);
  endtask

  task automatic t_jumps;
    @(posedge clk);
    z_ptr <= 16'hf123;
    run(op_relative_jump, 13'h0100, 12'hffb, 8'hff, 1, 13'h00fc, 0, 2);
    run(op_pointer_jump, 13'h0100, 12'h000, 8'hff, 1, 13'h1123, 0, 2);
    @(posedge clk);
    z_ptr <= 16'h0345;
    run(op_pointer_call, 13'h0200, 12'h000, 8'h00, 1, 13'h0345, 0, 3);
    chk("ret_addr", 16'h0201, ret_addr);
    chk("stack_top", 16'h0201, stack_top);
  endtask

  task automatic t_branches;
    setv(8'h00, 8'h00, 8'h00, 3'h7, 1'b0);
    for (int i = 0; i < 17; i++) begin
      run(bop[i], 13'h0020, 12'hff0, bft[i], 1, 13'h0011, 0, 2);
      run(bop[i], 13'h0020, 12'hff0, bff[i], 0, 13'h0000, 0, 1);
    end
  endtask

  task automatic t_skips;
    setv(8'h5a, 8'h5a, 8'h00, 3'h0, 1'b1);
    run(op_compare_skip_equal, 13'h0040, 0, 0, 1, 13'h0043, 0, 3);
    setv(8'h5a, 8'h5b, 8'h00, 3'h0, 1'b1);
    run(op_compare_skip_equal, 13'h0040, 0, 0, 0, 0, 0, 1);
    setv(8'hf7, 8'hf7, 8'h00, 3'h3, 1'b0);
    run(op_skip_reg_bit_clear, 13'h0040, 0, 0, 1, 13'h0042, 0, 2);
    run(op_skip_reg_bit_set, 13'h0040, 0, 0, 0, 0, 0, 1);
    setv(8'hf7, 8'hf7, 8'h00, 3'h4, 1'b1);
    run(op_skip_reg_bit_set, 13'h0040, 0, 0, 1, 13'h0043, 0, 3);
    run(op_skip_reg_bit_clear, 13'h0040, 0, 0, 0, 0, 0, 1);
    setv(8'h00, 8'h00, 8'h01, 3'h1, 1'b0);
    run(op_skip_io_bit_clear, 13'h0040, 0, 0, 1, 13'h0042, 0, 2);
    run(op_skip_io_bit_set, 13'h0040, 0, 0, 0, 0, 0, 1);
    setv(8'h00, 8'h00, 8'h01, 3'h0, 1'b0);
    run(op_skip_io_bit_set, 13'h0040, 0, 0, 1, 13'h0042, 0, 2);
  endtask

  task automatic t_cmpi;
    setv(8'h80, 8'h00, 8'h00, 3'h0, 1'b0);
    imm_val <= 8'h01;
    run(op_compare_immediate, 13'h0010, 0, 8'h91, 0, 0, 1, 1);
    chk("flags_out", 16'h00b8, flags_out);
    setv(8'h10, 8'h00, 8'h00, 3'h0, 1'b0);
    imm_val <= 8'h20;
    run(op_compare_immediate, 13'h0010, 0, 8'h00, 0, 0, 1, 1);
    chk("flags_out", 16'h0005, flags_out);
    setv(8'h80, 8'h00, 8'h00, 3'h0, 1'b0);
    imm_val <= 8'h80;
    run(op_compare_immediate, 13'h0010, 0, 8'h00, 0, 0, 1, 1);
    chk("flags_out", 16'h0002, flags_out);
  endtask

  // A held request while the core is stalled must not start anything
  task automatic t_stall;
    @(posedge clk);
    ce <= 1'b0;
    issue_valid <= 1'b1;
    issue_op <= op_relative_jump;
    repeat (3) @(posedge clk);
    #1;
    chk("issue_ready", 0, issue_ready);
    chk("pc_load", 0, pc_load);
    @(posedge clk);
    issue_valid <= 1'b0;
    ce <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #50000;
    fails++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    issue_valid = 1'b0;
    issue_op = op_relative_jump;
    pc = 13'h0000;
    offset = 12'h000;
    bit_sel = 3'h0;
    {rd_val, rr_val, imm_val, io_val, flags_in} = '0;
    z_ptr = 16'h0000;
    next_two_word = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("busy", 0, busy);
    chk("pc_load", 0, pc_load);
    chk("flags_out", 0, flags_out);
    chk("issue_ready", 1, issue_ready);
    t_jumps();
    t_branches();
    t_skips();
    t_cmpi();
    t_stall();
    test_done();
  end
endmodule
`default_nettype wire
